// ---- logic/nfe_ecc_engine.sv ----
// Notes on behaviour
// - nand-mode chip select gets single-bit ecc, 512 bytes
// - result read clears start; start write clears result
// - 8-bit: column p1..p4, row p8..p2048
// - 16-bit: column p1..p8, row p16..p2048
// - four-bit engine only on 8-bit devices
// - four-bit engine follows one selected chip select
// - ten-bit symbols, top two bits zero
// - parity or syndrome as eight ten-bit values
// - result read clears start; start write clears results
// - four-bit code covers up to 518 data bytes
// - zero syndrome means no errors
// - locate start computes address, value, state
// - error count, address and value reported
// - error read clears locate start; reads overlap
// - nand mode bit enables both engines
`include "nfe_params.svh"

module nfe_ecc_engine (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [3:0] nand_mode_i,
	input wire logic [3:0] cs_wide_i,
	input wire logic beat_valid_i,
	input wire logic [1:0] beat_cs_i,
	input wire logic [15:0] beat_data_i,
	input wire logic [3:0] ecc1_start_set_i,
	input wire logic [3:0] ecc1_result_rd_i,
	output logic [3:0] ecc1_start_o,
	output logic [95:0] ecc1_result_o,
	input wire logic ecc4_start_set_i,
	input wire logic [1:0] ecc4_cs_sel_i,
	input wire logic ecc4_result_rd_i,
	output logic ecc4_start_o,
	output logic [79:0] ecc4_result_o,
	output logic ecc4_syndrome_zero_o,
	input wire logic parity_load_i,
	input wire logic [9:0] parity_load_data_i,
	input wire logic locate_start_set_i,
	input wire logic error_reg_rd_i,
	output logic locate_start_o,
	output logic [3:0] ecc_state_o,
	output logic [2:0] error_count_o,
	output logic [9:0] error_address_o,
	output logic [9:0] error_value_o
);

	localparam nfe_pkg::nfe_sym_t ALPHA_INV = nfe_pkg::nfe_gf_pow(`NFE_GF_ORDER - 1);

	// ---------------- single-bit engines, one per chip select
	logic [3:0] lane_beat;

	genvar g;
	generate
		for (g = 0; g < `NFE_NUM_CS; g++) begin : gen_lane
			assign lane_beat[g] = beat_valid_i & (beat_cs_i == 2'(g)) & nand_mode_i[g];

			nfe_ecc1_lane u_lane (
				.clock_i(clock_i),
				.resetn_i(resetn_i),
				.beat_en_i(lane_beat[g]),
				.wide_i(cs_wide_i[g]),
				.data_i(beat_data_i),
				.start_set_i(ecc1_start_set_i[g]),
				.result_rd_i(ecc1_result_rd_i[g]),
				.start_o(ecc1_start_o[g]),
				.result_o(ecc1_result_o[g*`NFE_E1_W +: `NFE_E1_W])
			);
		end
	endgenerate

	// ---------------- four-bit engine, one selected chip select
	logic ecc4_start_r;
	logic sel_nand;
	logic sel_narrow;
	logic start_ok;
	logic beat_hit;
	logic e4_take;
	logic sym_valid;
	logic [9:0] sym;
	logic [9:0] sym_cnt;
	logic [79:0] rem;
	logic [79:0] syn;

	assign sel_nand = nand_mode_i[ecc4_cs_sel_i];
	assign sel_narrow = ~cs_wide_i[ecc4_cs_sel_i];
	// start is only taken while the selected chip select is in nand mode
	assign start_ok = ecc4_start_set_i & sel_nand;
	assign beat_hit = beat_valid_i & (beat_cs_i == ecc4_cs_sel_i);
	assign e4_take = ecc4_start_r & beat_hit & sel_nand & sel_narrow & (sym_cnt < `NFE_E4_MAX_BYTES);
	// a parity load wins over a data beat in the same cycle
	assign sym_valid = parity_load_i | e4_take;
	assign sym = parity_load_i ? parity_load_data_i : {2'b00, beat_data_i[7:0]};

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ecc4_start_r <= `NFE_START_RST;
		end else if (start_ok) begin
			ecc4_start_r <= 1'b1;
		end else if (ecc4_result_rd_i) begin
			ecc4_start_r <= 1'b0;
		end
	end

	nfe_ecc4_accum u_accum (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.clear_i(start_ok),
		.sym_valid_i(sym_valid),
		.sym_i(sym),
		.rem_o(rem),
		.syn_o(syn),
		.count_o(sym_cnt)
	);

	// value one is the lowest remainder coefficient
	assign ecc4_result_o = rem;
	assign ecc4_syndrome_zero_o = (rem == 80'h0);
	assign ecc4_start_o = ecc4_start_r;

	// ---------------- error location
	nfe_pkg::nfe_loc_e loc_state_r;
	logic locate_start_r;
	logic [7:0][9:0] snap_r;
	logic [6:0][9:0] prod_r;
	logic [6:0][9:0] prod_nxt;
	logic [9:0] val_r;
	logic [9:0] dist_r;
	logic [9:0] span_r;
	logic [3:0] state_r;
	logic [2:0] count_r;
	logic [9:0] addr_r;
	logic [9:0] value_r;
	logic syn_all_zero;
	logic hit;
	logic at_end;
	logic loc_run;
	logic loc_hit;
	logic loc_miss;
	logic loc_step;
	nfe_pkg::nfe_loc_e loc_state_nxt;
	logic [3:0] state_nxt;
	logic [2:0] count_nxt;
	logic [9:0] addr_nxt;
	logic [9:0] value_nxt;
	logic [79:0] snap_nxt;
	logic [69:0] prod_sel;
	logic [9:0] val_nxt;
	logic [9:0] dist_nxt;
	logic [9:0] span_nxt;

	assign syn_all_zero = (syn == 80'h0);

	// candidate position d matches when s[j]*alpha^d == s[j+1] for all j
	always_comb begin
		hit = (snap_r[0] != 10'h000);
		for (int j = 0; j < 7; j++) begin
			prod_nxt[j] = nfe_pkg::nfe_gf_mul(prod_r[j], `NFE_GF_ALPHA);
			if (prod_r[j] != snap_r[j+1]) begin
				hit = 1'b0;
			end
		end
	end

	assign at_end = (dist_r == span_r);

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			locate_start_r <= `NFE_START_RST;
		end else if (locate_start_set_i) begin
			locate_start_r <= 1'b1;
		end else if (error_reg_rd_i) begin
			locate_start_r <= 1'b0;
		end
	end

	// locator step decode
	assign loc_run = (loc_state_r == nfe_pkg::LOC_RUN);
	assign loc_hit = loc_run & hit;
	assign loc_miss = loc_run & ~hit & at_end;
	assign loc_step = loc_run & ~hit & ~at_end;

	always_comb begin
		loc_state_nxt = loc_state_r;
		case (loc_state_r)
			nfe_pkg::LOC_IDLE: begin
				loc_state_nxt = nfe_pkg::LOC_IDLE;
			end
			nfe_pkg::LOC_RUN: begin
				if (hit || at_end) begin
					loc_state_nxt = nfe_pkg::LOC_IDLE;
				end
			end
			default: begin
				loc_state_nxt = nfe_pkg::LOC_IDLE;
			end
		endcase
		if (locate_start_set_i) begin
			loc_state_nxt = syn_all_zero ? nfe_pkg::LOC_IDLE : nfe_pkg::LOC_RUN;
		end
	end

	assign state_nxt = locate_start_set_i ? (syn_all_zero ? `NFE_ST_NOERR : `NFE_ST_BUSY) :
		loc_hit ? `NFE_ST_FOUND : loc_miss ? `NFE_ST_FAIL : state_r;
	assign count_nxt = locate_start_set_i ? 3'h0 : loc_hit ? 3'h1 : count_r;
	// distance from the last symbol, as software expects
	assign addr_nxt = locate_start_set_i ? 10'h000 : loc_hit ? dist_r : addr_r;
	assign value_nxt = locate_start_set_i ? 10'h000 : loc_hit ? val_r : value_r;
	// syndromes are snapshotted, so a new read may accumulate meanwhile
	assign snap_nxt = locate_start_set_i ? syn : snap_r;
	assign prod_sel = locate_start_set_i ? syn[69:0] : loc_step ? prod_nxt : prod_r;
	assign val_nxt = locate_start_set_i ? syn[9:0] :
		loc_step ? nfe_pkg::nfe_gf_mul(val_r, ALPHA_INV) : val_r;
	assign dist_nxt = locate_start_set_i ? 10'h000 :
		loc_step ? dist_r + 10'h001 : dist_r;
	assign span_nxt = locate_start_set_i ? sym_cnt - 10'h001 : span_r;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			loc_state_r <= nfe_pkg::LOC_IDLE;
		end else begin
			loc_state_r <= loc_state_nxt;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			state_r <= `NFE_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			addr_r <= '0;
		end else begin
			addr_r <= addr_nxt;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			value_r <= '0;
		end else begin
			value_r <= value_nxt;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			snap_r <= '0;
		end else begin
			snap_r <= snap_nxt;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			prod_r <= '0;
		end else begin
			prod_r <= prod_sel;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			val_r <= `NFE_SYM_RST;
		end else begin
			val_r <= val_nxt;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			dist_r <= '0;
		end else begin
			dist_r <= dist_nxt;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			span_r <= '0;
		end else begin
			span_r <= span_nxt;
		end
	end

	assign locate_start_o = locate_start_r;
	assign ecc_state_o = state_r;
	assign error_count_o = count_r;
	assign error_address_o = addr_r;
	assign error_value_o = value_r;

endmodule : nfe_ecc_engine

// ---- shared/nfe_params.svh ----
`ifndef NFE_PARAMS_SVH
`define NFE_PARAMS_SVH

// chip selects and widths
`define NFE_NUM_CS 4
`define NFE_SYM_W 10
`define NFE_NPAR 8
`define NFE_E1_W 24
`define NFE_E1_IDX_W 12

// field positions inside a single-bit result word
`define NFE_E1_EVEN_LSB 0
`define NFE_E1_ODD_LSB 12

// block limits
`define NFE_E1_MAX_BYTES 10'h200
`define NFE_E4_MAX_BYTES 10'h206
`define NFE_CNT_SAT 10'h3ff

// field polynomial x^10 + x^3 + 1, low ten bits
`define NFE_GF_POLY 10'h009
`define NFE_GF_ALPHA 10'h002
`define NFE_GF_ONE 10'h001
`define NFE_GF_ORDER 1023

// reset values
`define NFE_START_RST 1'b0
`define NFE_E1_RES_RST 24'h000000
`define NFE_SYM_RST 10'h000

// correction state codes
`define NFE_ST_IDLE 4'h0
`define NFE_ST_NOERR 4'h1
`define NFE_ST_FOUND 4'h2
`define NFE_ST_FAIL 4'h3
`define NFE_ST_BUSY 4'h5

`endif

// ---- shared/nfe_pkg.sv ----
`include "nfe_params.svh"

package nfe_pkg;

	typedef logic [`NFE_SYM_W-1:0] nfe_sym_t;

	typedef enum logic {
		LOC_IDLE,
		LOC_RUN
	} nfe_loc_e;

	// multiply in the ten-bit field
	function automatic nfe_sym_t nfe_gf_mul(input nfe_sym_t a, input nfe_sym_t b);
		nfe_sym_t p;
		nfe_sym_t x;
		p = '0;
		x = a;
		for (int i = 0; i < `NFE_SYM_W; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = x[9] ? ({x[8:0], 1'b0} ^ `NFE_GF_POLY) : {x[8:0], 1'b0};
		end
		return p;
	endfunction : nfe_gf_mul

	function automatic nfe_sym_t nfe_gf_pow(input int e);
		nfe_sym_t r;
		r = `NFE_GF_ONE;
		for (int i = 0; i < e; i++) begin
			r = nfe_gf_mul(r, `NFE_GF_ALPHA);
		end
		return r;
	endfunction : nfe_gf_pow

	// product of (x + alpha^j), j = 1..8, low eight coefficients
	function automatic logic [79:0] nfe_gen_poly();
		logic [8:0][9:0] g;
		nfe_sym_t r;
		g = '0;
		g[0] = `NFE_GF_ONE;
		for (int j = 1; j <= `NFE_NPAR; j++) begin
			r = nfe_gf_pow(j);
			for (int k = `NFE_NPAR; k >= 1; k--) begin
				g[k] = g[k-1] ^ nfe_gf_mul(g[k], r);
			end
			g[0] = nfe_gf_mul(g[0], r);
		end
		return g[7:0];
	endfunction : nfe_gen_poly

endpackage : nfe_pkg

// ---- logic/nfe_ecc1_lane.sv ----
`include "nfe_params.svh"

module nfe_ecc1_lane (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic beat_en_i,
	input wire logic wide_i,
	input wire logic [15:0] data_i,
	input wire logic start_set_i,
	input wire logic result_rd_i,
	output logic start_o,
	output logic [`NFE_E1_W-1:0] result_o
);

	logic start_r;
	logic [`NFE_E1_W-1:0] acc_r;
	logic [9:0] cnt_r;
	logic take;
	logic [9:0] step;

	// odd parity over set index bits, even parity over clear ones
	function automatic logic [23:0] beat_par(input logic [15:0] d, input logic w, input logic [9:0] c);
		logic [11:0] idx;
		logic [11:0] odd;
		logic [11:0] even;
		odd = '0;
		even = '0;
		for (int i = 0; i < 16; i++) begin
			idx = w ? {c[8:1], 4'(i)} : {c[8:0], 3'(i)};
			if (w || i < 8) begin
				odd = odd ^ (idx & {12{d[i]}});
				even = even ^ (~idx & {12{d[i]}});
			end
		end
		return {odd, even};
	endfunction : beat_par

	// beats past the block limit leave the result untouched
	assign take = start_r & beat_en_i & (cnt_r < `NFE_E1_MAX_BYTES);
	assign step = wide_i ? 10'h002 : 10'h001;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			start_r <= `NFE_START_RST;
			acc_r <= `NFE_E1_RES_RST;
			cnt_r <= '0;
		end else if (start_set_i) begin
			start_r <= 1'b1;
			acc_r <= `NFE_E1_RES_RST;
			cnt_r <= '0;
		end else begin
			if (result_rd_i) begin
				start_r <= 1'b0;
			end
			if (take) begin
				acc_r <= acc_r ^ beat_par(data_i, wide_i, cnt_r);
				cnt_r <= cnt_r + step;
			end
		end
	end

	assign start_o = start_r;
	assign result_o = acc_r;

endmodule : nfe_ecc1_lane

// ---- logic/nfe_ecc4_accum.sv ----
`include "nfe_params.svh"

module nfe_ecc4_accum (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic clear_i,
	input wire logic sym_valid_i,
	input wire logic [9:0] sym_i,
	output logic [79:0] rem_o,
	output logic [79:0] syn_o,
	output logic [9:0] count_o
);

	localparam logic [79:0] GEN = nfe_pkg::nfe_gen_poly();

	logic [7:0][9:0] rem_r;
	logic [7:0][9:0] rem_nxt;
	logic [7:0][9:0] syn_r;
	logic [7:0][9:0] syn_nxt;
	logic [9:0] cnt_r;
	logic [9:0] fb;

	assign fb = sym_i ^ rem_r[7];

	// division by the generator and horner evaluation at alpha^1..alpha^8
	always_comb begin
		for (int k = 0; k < `NFE_NPAR; k++) begin
			rem_nxt[k] = nfe_pkg::nfe_gf_mul(fb, GEN[k*10 +: 10]);
			if (k > 0) begin
				rem_nxt[k] = rem_nxt[k] ^ rem_r[k-1];
			end
			syn_nxt[k] = nfe_pkg::nfe_gf_mul(syn_r[k], nfe_pkg::nfe_gf_pow(k + 1)) ^ sym_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i || clear_i) begin
			rem_r <= '0;
			syn_r <= '0;
			cnt_r <= '0;
		end else if (sym_valid_i) begin
			rem_r <= rem_nxt;
			syn_r <= syn_nxt;
			cnt_r <= (cnt_r == `NFE_CNT_SAT) ? cnt_r : cnt_r + 10'h001;
		end
	end

	assign rem_o = rem_r;
	assign syn_o = syn_r;
	assign count_o = cnt_r;

endmodule : nfe_ecc4_accum

// ---- tb/nfe_ecc_engine_monitor.sv ----
module nfe_ecc_engine_monitor (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [3:0] nand_mode_i,
	input wire logic [3:0] cs_wide_i,
	input wire logic beat_valid_i,
	input wire logic [1:0] beat_cs_i,
	input wire logic [3:0] ecc1_start_set_i,
	input wire logic [3:0] ecc1_result_rd_i,
	input wire logic [3:0] ecc1_start_o,
	input wire logic [95:0] ecc1_result_o,
	input wire logic ecc4_start_set_i,
	input wire logic [1:0] ecc4_cs_sel_i,
	input wire logic ecc4_result_rd_i,
	input wire logic ecc4_start_o,
	input wire logic [79:0] ecc4_result_o,
	input wire logic ecc4_syndrome_zero_o,
	input wire logic parity_load_i,
	input wire logic locate_start_set_i,
	input wire logic error_reg_rd_i,
	input wire logic locate_start_o,
	input wire logic [3:0] ecc_state_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);
	chk_e1_set: assert property (ecc1_start_set_i != 4'h0 |=>
		(ecc1_start_o & $past(ecc1_start_set_i)) == $past(ecc1_start_set_i)) else $error("start bit not set");
	chk_e1_rdclr: assert property (ecc1_result_rd_i[1] && !ecc1_start_set_i[1] |=>
		!ecc1_start_o[1]) else $error("start bit not cleared by read");
	chk_e1_clear: assert property (ecc1_start_set_i[0] |=>
		ecc1_result_o[23:0] == 24'h000000) else $error("result not cleared by start");
	chk_e1_quiet: assert property (!(beat_valid_i && beat_cs_i == 2'h0) && !ecc1_start_set_i[0] |=>
		$stable(ecc1_result_o[23:0])) else $error("result moved without a beat");
	chk_e4_start: assert property (ecc4_start_set_i && nand_mode_i[ecc4_cs_sel_i] |=>
		ecc4_start_o && ecc4_result_o == 80'h0) else $error("four-bit start failed");
	chk_e4_rdclr: assert property (ecc4_result_rd_i && !ecc4_start_set_i |=>
		!ecc4_start_o) else $error("four-bit start not cleared");
	chk_e4_skip: assert property (beat_valid_i && (cs_wide_i[beat_cs_i] || beat_cs_i != ecc4_cs_sel_i)
		&& !parity_load_i && !ecc4_start_set_i |=> $stable(ecc4_result_o)) else $error("foreign beat taken");
	chk_syn_flag: assert property (ecc4_syndrome_zero_o == (ecc4_result_o == 80'h0))
		else $error("zero flag wrong");
	chk_loc_busy: assert property (locate_start_set_i |=>
		locate_start_o && ecc_state_o inside {4'h1, 4'h5}) else $error("locate start not taken");
	chk_loc_done: assert property (locate_start_set_i |->
		##[1:600] ecc_state_o inside {4'h1, 4'h2, 4'h3}) else $error("locate never done");
	chk_loc_rdclr: assert property (error_reg_rd_i && !locate_start_set_i |=>
		!locate_start_o) else $error("locate start not cleared");
endmodule : nfe_ecc_engine_monitor

// ---- tb/nfe_flash_model.sv ----
module nfe_flash_model (
	input wire logic clock_i,
	input wire logic go_i,
	input wire logic [1:0] cs_i,
	input wire logic [10:0] len_i,
	input wire logic slow_i,
	output logic busy_o,
	output logic beat_valid_o,
	output logic [1:0] beat_cs_o,
	output logic [15:0] beat_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] page [0:1023];
	initial begin
		busy_o = 1'b0;
		beat_valid_o = 1'b0;
		beat_cs_o = 2'h0;
		beat_data_o = 16'h0000;
		forever begin
			@(posedge clock_i);
			if (go_i) begin
				for (int i = 0; i < len_i; i++) begin
					#1;
					busy_o = 1'b1;
					beat_valid_o = 1'b1;
					beat_cs_o = cs_i;
					beat_data_o = page[i];
					@(posedge clock_i);
					if (slow_i) begin
						#1;
						beat_valid_o = 1'b0;
						beat_data_o = ~beat_data_o;
						@(posedge clock_i);
					end
				end
				#1;
				busy_o = 1'b0;
				beat_valid_o = 1'b0;
				beat_data_o = ~beat_data_o;
			end
		end
	end
endmodule : nfe_flash_model

// ---- tb/nfe_ecc_engine_tb.sv ----
module nfe_ecc_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, resetn_i, go, fslow, fbusy, beat_valid_i, ecc4_start_set_i, ecc4_result_rd_i, ecc4_start_o;
	logic ecc4_syndrome_zero_o, parity_load_i, locate_start_set_i, error_reg_rd_i, locate_start_o;
	logic [3:0] nand_mode_i, cs_wide_i, ecc1_start_set_i, ecc1_result_rd_i, ecc1_start_o, ecc_state_o;
	logic [1:0] beat_cs_i, ecc4_cs_sel_i, fcs, n4;
	logic [15:0] beat_data_i;
	logic [95:0] ecc1_result_o;
	logic [79:0] ecc4_result_o, par;
	logic [9:0] parity_load_data_i, error_address_o, error_value_o;
	logic [10:0] flen;
	logic [2:0] error_count_o;
	logic [31:0] seed;
	logic [25:0] n1;
	logic [7:0] err;
	logic [25:0] q1[$];
	logic [1:0] q4[$];
	logic [26:0] ql[$];
	int fails, n_compared, pos;
	nfe_ecc_engine dut (.clock_i, .resetn_i, .nand_mode_i, .cs_wide_i, .beat_valid_i, .beat_cs_i, .beat_data_i,
		.ecc1_start_set_i, .ecc1_result_rd_i, .ecc1_start_o, .ecc1_result_o, .ecc4_start_set_i, .ecc4_cs_sel_i,
		.ecc4_result_rd_i, .ecc4_start_o, .ecc4_result_o, .ecc4_syndrome_zero_o, .parity_load_i,
		.parity_load_data_i, .locate_start_set_i, .error_reg_rd_i, .locate_start_o, .ecc_state_o,
		.error_count_o, .error_address_o, .error_value_o);
	nfe_flash_model fl (.clock_i, .go_i(go), .cs_i(fcs), .len_i(flen), .slow_i(fslow), .busy_o(fbusy),
		.beat_valid_o(beat_valid_i), .beat_cs_o(beat_cs_i), .beat_data_o(beat_data_i));
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	task tick;
		@(posedge clock_i);
		#1;
	endtask : tick
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task tally(input logic bad, input string what);
		n_compared++;
		if (bad !== 1'b0) begin
			fails++;
			$display("FAIL %0t %s", $time, what);
		end
	endtask : tally
	task cmp1(input logic [23:0] got, input logic [23:0] exp);
		tally(got !== exp, "single-bit result");
	endtask : cmp1
	task cmp4(input logic got, input logic exp);
		tally(got !== exp, "syndrome zero flag");
	endtask : cmp4
	task cmpl(input logic [26:0] got, input logic [26:0] exp);
		tally(got !== exp, "locator result");
	endtask : cmpl
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// even bit k toggles on index bit k clear, odd on set
	function automatic logic [23:0] e1_exp(input int cnt, input int sh);
		logic [11:0] ev, od, ix;
		ev = 12'h000;
		od = 12'h000;
		for (int a = 0; a < cnt && a < (512 >> (sh - 3)); a++) begin
			for (int b = 0; b < (1 << sh); b++) begin
				ix = 12'((a << sh) | b);
				if (fl.page[a][b]) begin
					ev = ev ^ ~ix;
					od = od ^ ix;
				end
			end
		end
		return {od, ev};
	endfunction : e1_exp
	task stream(input logic [1:0] cs, input int len, input logic slow);
		int n;
		fcs = cs;
		flen = 11'(len);
		fslow = slow;
		go = 1'b1;
		tick;
		go = 1'b0;
		for (n = 0; n < 3000; n++) begin
			tick;
			if (!fbusy) break;
		end
		if (n == 3000) begin
			fails++;
			report_and_stop();
		end
	endtask : stream
	task rd1(input int n, input logic [23:0] exp);
		q1.push_back({2'(n), exp});
		ecc1_result_rd_i = 4'h1 << n;
		tick;
		ecc1_result_rd_i = 4'h0;
	endtask : rd1
	task e4_rd(input logic [1:0] e);
		q4.push_back(e);
		ecc4_result_rd_i = 1'b1;
		tick;
		ecc4_result_rd_i = 1'b0;
	endtask : e4_rd
	task e4_start;
		ecc4_start_set_i = 1'b1;
		tick;
		ecc4_start_set_i = 1'b0;
	endtask : e4_start
	task e4_check(input logic zero);
		e4_start();
		stream(2'h1, 520, 1'b0);
		tick;
		e4_rd(2'b00);
		for (int k = 8; k >= 1; k--) begin
			parity_load_i = 1'b1;
			parity_load_data_i = par[k*10-1 -: 10];
			tick;
		end
		parity_load_i = 1'b0;
		tick;
		e4_rd({1'b1, zero});
	endtask : e4_check
	always @(posedge clock_i) begin
		if (|ecc1_result_rd_i) begin
			n1 = q1.pop_front();
			cmp1(ecc1_result_o[n1[25:24]*24 +: 24], n1[23:0]);
		end
		if (ecc4_result_rd_i) begin
			n4 = q4.pop_front();
			if (n4[1]) cmp4(ecc4_syndrome_zero_o, n4[0]);
		end
		if (error_reg_rd_i) cmpl({ecc_state_o, error_count_o, error_address_o, error_value_o}, ql.pop_front());
	end
	initial begin
		{resetn_i, go, fslow, ecc4_start_set_i, ecc4_result_rd_i, parity_load_i} = 6'h00;
		{locate_start_set_i, error_reg_rd_i, fcs, flen} = 15'h0000;
		{ecc1_start_set_i, ecc1_result_rd_i, parity_load_data_i} = 18'h00000;
		nand_mode_i = 4'h7;
		cs_wide_i = 4'h4;
		ecc4_cs_sel_i = 2'h1;
		fails = 0;
		n_compared = 0;
		seed = 32'h00011323;
		for (int i = 0; i < 1024; i++) begin
			seed = lfsr_next(seed);
			fl.page[i] = seed[15:0];
		end
		repeat (6) @(posedge clock_i);
		#1;
		resetn_i = 1'b1;
		ecc1_start_set_i = 4'hf;
		tick;
		ecc1_start_set_i = 4'h0;
		stream(2'h0, 520, 1'b0);
		stream(2'h1, 16, 1'b1);
		stream(2'h2, 20, 1'b0);
		stream(2'h3, 8, 1'b0);
		rd1(0, e1_exp(520, 3));
		rd1(1, e1_exp(16, 3));
		rd1(2, e1_exp(20, 4));
		rd1(3, 24'h000000);
		ecc1_start_set_i = 4'h1;
		tick;
		ecc1_start_set_i = 4'h0;
		rd1(0, 24'h000000);
		e4_start();
		stream(2'h2, 20, 1'b0);
		stream(2'h1, 518, 1'b0);
		stream(2'h0, 10, 1'b0);
		tick;
		par = ecc4_result_o;
		e4_rd(2'b00);
		e4_check(1'b1);
		seed = lfsr_next(seed);
		pos = int'(seed[8:0]);
		err = seed[23:16] | 8'h01;
		fl.page[pos] = fl.page[pos] ^ {8'h00, err};
		e4_check(1'b0);
		ql.push_back({4'h2, 3'h1, 10'(525 - pos), {2'b00, err}});
		locate_start_set_i = 1'b1;
		tick;
		locate_start_set_i = 1'b0;
		for (pos = 0; pos < 700 && !(ecc_state_o inside {4'h1, 4'h2, 4'h3}); pos++) tick;
		if (pos == 700) fails++;
		error_reg_rd_i = 1'b1;
		tick;
		error_reg_rd_i = 1'b0;
		tick;
		report_and_stop();
	end
endmodule : nfe_ecc_engine_tb
bind nfe_ecc_engine nfe_ecc_engine_monitor mon (.clock_i, .resetn_i, .nand_mode_i, .cs_wide_i, .beat_valid_i,
	.beat_cs_i, .ecc1_start_set_i, .ecc1_result_rd_i, .ecc1_start_o, .ecc1_result_o, .ecc4_start_set_i,
	.ecc4_cs_sel_i, .ecc4_result_rd_i, .ecc4_start_o, .ecc4_result_o, .ecc4_syndrome_zero_o, .parity_load_i,
	.locate_start_set_i, .error_reg_rd_i, .locate_start_o, .ecc_state_o);
